// >>> rtl/gpp_consts.vh
// register map, field positions, encodings and reset values for the gpio port
`ifndef GPP_CONSTS_VH
`define GPP_CONSTS_VH

// register byte offsets
`define GPP_OFS_DATA_OUT 12'h000
`define GPP_OFS_PIN_STATE 12'h004
`define GPP_OFS_DRIVE_MODE 12'h008
`define GPP_OFS_CONFIG 12'h00c
`define GPP_OFS_SOURCE_SEL 12'h010
`define GPP_OFS_HOLD 12'h014
`define GPP_OFS_IRQ_STATUS 12'h018
`define GPP_OFS_IRQ_CLEAR 12'h01c
`define GPP_OFS_IRQ_ENABLE 12'h020
`define GPP_OFS_IRQ_EDGE 12'h024

// config register fields: [7:0] input buffer enable, [15:8] output buffer enable,
// [23:16] threshold select (1 = low-voltage ttl), [31:24] slow slew select
`define GPP_CFG_IBUF_LSB 5'h00
`define GPP_CFG_OBUF_LSB 5'h08
`define GPP_CFG_VTRIP_LSB 5'h10
`define GPP_CFG_SLEW_LSB 5'h18

// drive modes, three bits per pin
`define GPP_DM_ANALOG 3'h0
`define GPP_DM_INPUT 3'h1
`define GPP_DM_WPU_SPD 3'h2
`define GPP_DM_SPU_WPD 3'h3
`define GPP_DM_OD_SPD 3'h4
`define GPP_DM_OD_SPU 3'h5
`define GPP_DM_STRONG 3'h6
`define GPP_DM_WPU_WPD 3'h7

// pin source select, two bits per pin
`define GPP_SRC_DATA 2'h0
`define GPP_SRC_FIXED 2'h1
`define GPP_SRC_FABRIC 2'h2

// reset values
`define GPP_RST_DATA 8'h00
`define GPP_RST_MODE 24'h000000
`define GPP_RST_CONFIG 32'h00000000
`define GPP_RST_SRC 16'h0000

`endif

// >>> rtl/gpp_sync.v
// two-stage synchroniser for the eight pin input levels
`timescale 1ns/1ps
module gpp_sync (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // levels
    input wire [7:0] din,
    output reg [7:0] dout
);
    reg [7:0] stage1;

    // stage1 feeds only the second stage, never any logic
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1 <= 8'h00;
            dout <= 8'h00;
        end else begin
            stage1 <= din;
            dout <= stage1;
        end
    end
endmodule

// >>> rtl/gpp_pin_cell.v
// one pin: drive mode decode, buffer enables, source mux and hold latch
`timescale 1ns/1ps
`include "gpp_consts.vh"
module gpp_pin_cell (
    // clock and reset
    input wire pclk,
    input wire presetn,
    // configuration
    input wire [2:0] drive_mode,
    input wire ibuf_en,
    input wire obuf_en,
    input wire [1:0] source_sel,
    input wire hold,
    // candidate sources
    input wire data_bit,
    input wire fixed_bit,
    input wire fabric_bit,
    // pad controls
    output reg pad_out,
    output reg pad_oe_n,
    output reg pad_in_en,
    output reg pad_pull_up,
    output reg pad_pull_down
);
    reg sel_bit;
    reg drive_val;
    reg drive_n;
    reg in_en;
    reg pu;
    reg pd;

    // source mux and drive mode decode
    always @* begin
        case (source_sel)
            // fixed signals on their own input
            `GPP_SRC_FIXED: sel_bit = fixed_bit;
            `GPP_SRC_FABRIC: sel_bit = fabric_bit;
            default: sel_bit = data_bit;
        endcase
        drive_val = sel_bit;
        drive_n = 1'b1;
        in_en = ibuf_en;
        pu = 1'b0;
        pd = 1'b0;
        // eight drive modes; weak drive is modelled as a pull, not a driven level
        case (drive_mode)
            `GPP_DM_ANALOG: begin
                in_en = 1'b0;
            end
            `GPP_DM_INPUT: begin
                drive_n = 1'b1;
            end
            // weak level only while the driver is off, so a pull never fights it
            `GPP_DM_WPU_SPD: begin
                drive_n = sel_bit;
                pu = sel_bit;
            end
            `GPP_DM_SPU_WPD: begin
                drive_n = ~sel_bit;
                pd = ~sel_bit;
            end
            `GPP_DM_OD_SPD: begin
                drive_n = sel_bit;
            end
            `GPP_DM_OD_SPU: begin
                drive_n = ~sel_bit;
            end
            `GPP_DM_STRONG: begin
                drive_n = 1'b0;
            end
            default: begin
                pu = sel_bit;
                pd = ~sel_bit;
            end
        endcase
        // output buffer enable on top of the mode
        if (!obuf_en) begin
            drive_n = 1'b1;
            pu = 1'b0;
            pd = 1'b0;
        end
    end

    // hold keeps the last pad state; reset forces everything off
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_out <= 1'b0;
            pad_oe_n <= 1'b1;
            pad_in_en <= 1'b0;
            pad_pull_up <= 1'b0;
            pad_pull_down <= 1'b0;
        end else if (!hold) begin
            pad_out <= drive_val;
            pad_oe_n <= drive_n;
            pad_in_en <= in_en;
            pad_pull_up <= pu;
            pad_pull_down <= pd;
        end
    end
endmodule

// >>> rtl/gpp_port.v
// eight-pin gpio port with apb registers, pin source mux, hold and interrupt
//
// Overview of operation
// - Each pin picks one of eight drive modes from its three-bit mode field.
// - The analog mode turns off the pin's input buffer and its output driver.
// - Each pin has a threshold select bit choosing cmos or low-voltage ttl input levels.
// - Input and output buffer enables are separate per-pin bits applied over the mode.
// - A hold bit freezes the pin at its last driven state through deep sleep and hibernate.
// - Each pin has a slew select bit choosing fast or slow output edges.
// - The port has eight pins; drive mode and source select give each pin a multi-bit field, and hold is one bit for all pins.
// - During reset every pin is disabled, neither driving nor sensing.
// - A per-pin selector connects the port data bit or a peripheral signal to the pin.
// - Fixed-function signals arrive on their own dedicated input, one per pin, not via fabric.
// - Any pin may take a fabric signal and hands its level back to the fabric.
// - The data output register holds driven values and the pin-state register reads levels.
// - A pin raises an interrupt only when its enable bit is set.
// - All pin interrupts of the port merge into one request line for the port.
//
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/1ps
`include "gpp_consts.vh"
module gpp_port (
    // apb slave
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    // power state
    input wire low_power,
    // peripheral sources
    input wire [7:0] fixed_out,
    input wire [7:0] fabric_out,
    output reg [7:0] fabric_in,
    // pads
    input wire [7:0] pad_in,
    output wire [7:0] pad_out,
    output wire [7:0] pad_oe_n,
    output wire [7:0] pad_in_en,
    output wire [7:0] pad_pull_up,
    output wire [7:0] pad_pull_down,
    output reg [7:0] pad_vtrip_ttl,
    output reg [7:0] pad_slew_slow,
    // interrupt
    output reg port_irq
);
    reg [7:0] data_out;
    reg [23:0] drive_mode;
    reg [31:0] config_reg;
    reg [15:0] source_sel;
    reg hold_sw;
    reg [7:0] irq_status;
    reg [7:0] irq_enable;
    reg [7:0] irq_edge;
    reg [7:0] pin_prev;
    reg [31:0] next_prdata;
    reg next_pslverr;
    wire [7:0] pin_state;
    wire hold;
    wire wr_en;
    wire [7:0] edge_evt;
    wire [7:0] clr_mask;

    // byte-wide field of the config register at a given lsb
    function [7:0] cfg_field;
        input [31:0] cfg;
        input [4:0] lsb;
        begin
            cfg_field = cfg[lsb +: 8];
        end
    endfunction

    // writes land in the access phase so the master's setup cycle is only decoded
    assign wr_en = psel & penable & pwrite;
    // software hold or any low-power state freezes the pin-cell pad controls, not threshold or slew
    assign hold = hold_sw | low_power;

    gpp_sync u_sync (
        .pclk(pclk),
        .presetn(presetn),
        .din(pad_in),
        .dout(pin_state)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_pin
            gpp_pin_cell u_cell (
                .pclk(pclk),
                .presetn(presetn),
                .drive_mode(drive_mode[3*gi +: 3]),
                .ibuf_en(config_reg[`GPP_CFG_IBUF_LSB + gi]),
                .obuf_en(config_reg[`GPP_CFG_OBUF_LSB + gi]),
                .source_sel(source_sel[2*gi +: 2]),
                .hold(hold),
                .data_bit(data_out[gi]),
                .fixed_bit(fixed_out[gi]),
                .fabric_bit(fabric_out[gi]),
                .pad_out(pad_out[gi]),
                .pad_oe_n(pad_oe_n[gi]),
                .pad_in_en(pad_in_en[gi]),
                .pad_pull_up(pad_pull_up[gi]),
                .pad_pull_down(pad_pull_down[gi])
            );
        end
    endgenerate

    // edge events: rising by default, falling where the edge bit is set
    assign edge_evt = (pin_state & ~pin_prev & ~irq_edge) | (~pin_state & pin_prev & irq_edge);
    assign clr_mask = (wr_en && paddr == `GPP_OFS_IRQ_CLEAR) ? pwdata[7:0] : 8'h00;

    // control registers written by software
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_out <= `GPP_RST_DATA;
            drive_mode <= `GPP_RST_MODE;
            config_reg <= `GPP_RST_CONFIG;
            source_sel <= `GPP_RST_SRC;
            hold_sw <= 1'b0;
            irq_enable <= 8'h00;
            irq_edge <= 8'h00;
        end else if (wr_en) begin
            case (paddr)
                `GPP_OFS_DATA_OUT: data_out <= pwdata[7:0];
                `GPP_OFS_DRIVE_MODE: drive_mode <= pwdata[23:0];
                `GPP_OFS_CONFIG: config_reg <= pwdata;
                `GPP_OFS_SOURCE_SEL: source_sel <= pwdata[15:0];
                `GPP_OFS_HOLD: hold_sw <= pwdata[0];
                `GPP_OFS_IRQ_ENABLE: irq_enable <= pwdata[7:0];
                `GPP_OFS_IRQ_EDGE: irq_edge <= pwdata[7:0];
                default: hold_sw <= hold_sw;
            endcase
        end
    end

    // sticky status; a new edge beats a clear in the same cycle
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_prev <= 8'h00;
            irq_status <= 8'h00;
        end else begin
            pin_prev <= pin_state;
            // detection runs on the synchronised level
            irq_status <= (irq_status & ~clr_mask) | edge_evt;
        end
    end

    // registered pad attributes and the port request
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pad_vtrip_ttl <= 8'h00;
            pad_slew_slow <= 8'h00;
            fabric_in <= 8'h00;
            port_irq <= 1'b0;
        end else begin
            pad_vtrip_ttl <= cfg_field(config_reg, `GPP_CFG_VTRIP_LSB);
            pad_slew_slow <= cfg_field(config_reg, `GPP_CFG_SLEW_LSB);
            // every pin reaches the fabric; gated by input enable
            fabric_in <= pin_state & cfg_field(config_reg, `GPP_CFG_IBUF_LSB);
            // enabled bits merged to one line; lags status by one cycle
            port_irq <= |(irq_status & irq_enable);
        end
    end

    // read mux, evaluated in the setup cycle and registered for the access phase
    always @* begin
        next_prdata = 32'h00000000;
        next_pslverr = 1'b0;
        case (paddr)
            `GPP_OFS_DATA_OUT: next_prdata = {24'h000000, data_out};
            `GPP_OFS_PIN_STATE: next_prdata = {24'h000000, pin_state};
            `GPP_OFS_DRIVE_MODE: next_prdata = {8'h00, drive_mode};
            `GPP_OFS_CONFIG: next_prdata = config_reg;
            `GPP_OFS_SOURCE_SEL: next_prdata = {16'h0000, source_sel};
            `GPP_OFS_HOLD: next_prdata = {31'h00000000, hold_sw};
            `GPP_OFS_IRQ_STATUS: next_prdata = {24'h000000, irq_status};
            `GPP_OFS_IRQ_CLEAR: next_prdata = 32'h00000000;
            `GPP_OFS_IRQ_ENABLE: next_prdata = {24'h000000, irq_enable};
            `GPP_OFS_IRQ_EDGE: next_prdata = {24'h000000, irq_edge};
            default: next_pslverr = 1'b1;
        endcase
    end

    // apb answer: pready rises in the first access cycle, so no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & next_pslverr;
            if (psel && !penable && !pwrite) begin
                prdata <= next_prdata;
            end
        end
    end
endmodule

// >>> test/gpp_port_properties.sv
// concurrent checks on the gpio port apb handshake and pad outputs
`timescale 1ns/1ps
module gpp_port_properties (
    // apb side
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    // pads and interrupt
    input wire low_power,
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe_n,
    input wire [7:0] pad_in_en,
    input wire [7:0] pad_pull_up,
    input wire [7:0] pad_pull_down,
    input wire port_irq
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    setup_answer_a: assert property (psel && !penable |=> pready)
        else $error("no ready after setup cycle");
    ready_single_a: assert property (pready |=> !pready)
        else $error("ready held past one cycle");
    ready_access_a: assert property (pready |-> psel && penable)
        else $error("ready outside access phase");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error without ready");
    err_zero_a: assert property (pslverr && !pwrite |-> prdata == 32'h00000000)
        else $error("refused read returned data");
    pads_off_a: assert property ($rose(presetn) |->
        pad_oe_n == 8'hff && pad_in_en == 8'h00 && !port_irq)
        else $error("pads not disabled after reset");
    // weak pulls never fight the driver
    pull_excl_a: assert property ((pad_pull_up & pad_pull_down) == 8'h00 &&
        (~pad_oe_n & (pad_pull_up | pad_pull_down)) == 8'h00)
        else $error("pull enables conflict");
    lp_freeze_a: assert property ($past(low_power, 1) && $past(low_power, 2) |->
        $stable(pad_out) && $stable(pad_oe_n) && $stable(pad_in_en))
        else $error("pads moved during low power");
endmodule

bind gpp_port gpp_port_properties u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .low_power(low_power), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
    .pad_in_en(pad_in_en), .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down),
    .port_irq(port_irq));

// >>> test/gpp_pad_model.sv
// external circuit at the eight pins: resolves each wire level
`timescale 1ns/1ps
module gpp_pad_model (
    // clock for the floating pattern
    input wire pclk,
    // device pad controls
    input wire [7:0] pad_out,
    input wire [7:0] pad_oe_n,
    input wire [7:0] pad_pull_up,
    input wire [7:0] pad_pull_down,
    // outside drivers
    input wire [7:0] ext_drive,
    input wire [7:0] ext_en,
    output logic [7:0] pad_in
);
    logic [7:0] float_pat = 8'h55;
    // an undriven pin wanders so a stale level can never pass
    always @(posedge pclk) float_pat <= ~float_pat;
    // device driver wins, then outside driver, then pulls
    always @* begin
        for (int i = 0; i < 8; i++) begin
            pad_in[i] = !pad_oe_n[i] ? pad_out[i] : ext_en[i] ? ext_drive[i] :
                pad_pull_up[i] ? 1'b1 : pad_pull_down[i] ? 1'b0 : float_pat[i];
        end
    end
endmodule

// >>> test/gpp_port_bench.sv
// self-checking bench for the gpio port
`timescale 1ns/1ps
`include "gpp_consts.vh"
module gpp_port_bench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, low_power = 0, ev;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rv;
    logic [7:0] fixed_out = 8'h3c, fabric_out = 8'hc3, ext_drive = 8'h00, ext_en = 8'h00;
    wire [31:0] prdata;
    wire pready, pslverr, port_irq;
    wire [7:0] fabric_in, pad_in, pad_out, pad_oe_n, pad_in_en, pad_pull_up, pad_pull_down;
    wire [7:0] pad_vtrip_ttl, pad_slew_slow;
    int num_errors = 0, comparisons = 0, cyc = 0;
    // per mode with data 0f: oe_n, pull up, pull down, input enable
    logic [31:0] rows [0:7] = '{32'hff000000, 32'hff0000ff, 32'h0f0f00ff, 32'hf000f0ff,
        32'h0f0000ff, 32'hf00000ff, 32'h000000ff, 32'hff0ff0ff};
    gpp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_power(low_power), .fixed_out(fixed_out),
        .fabric_out(fabric_out), .fabric_in(fabric_in), .pad_in(pad_in), .pad_out(pad_out),
        .pad_oe_n(pad_oe_n), .pad_in_en(pad_in_en), .pad_pull_up(pad_pull_up),
        .pad_pull_down(pad_pull_down), .pad_vtrip_ttl(pad_vtrip_ttl),
        .pad_slew_slow(pad_slew_slow), .port_irq(port_irq));
    gpp_pad_model u_pads (.pclk(pclk), .pad_out(pad_out), .pad_oe_n(pad_oe_n),
        .pad_pull_up(pad_pull_up), .pad_pull_down(pad_pull_down), .ext_drive(ext_drive),
        .ext_en(ext_en), .pad_in(pad_in));
    // 40 mhz clock
    always #12.5 pclk = ~pclk;
    // hang guard, far above the few hundred cycles the tests need
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            num_errors++;
            final_report();
        end
    end
    task final_report;
        $display("comparisons %0d, mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer; waits for ready, never assumes a latency
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // only the bench's cycle ceiling ends this wait
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rv = prdata;
        ev = pslverr;
        psel <= 0;
        penable <= 0;
    endtask
    task tick(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask
    initial begin
        repeat (10) @(posedge pclk);
        presetn <= 1;
        tick(1);
        chk(pad_oe_n, 8'hff);
        chk(pad_in_en, 8'h00);
        chk(port_irq, 1'b0);
        foreach (rows[i]) if (i < 5 && i != 1) begin
            apb(0, i * 4, 0);
            chk(rv, 32'h0);
        end
        $display("end of test reset");
        apb(1, `GPP_OFS_CONFIG, 32'h0000ffff);
        apb(1, `GPP_OFS_DATA_OUT, 32'h0f);
        for (int m = 0; m < 8; m++) begin
            apb(1, `GPP_OFS_DRIVE_MODE, {8{m[2:0]}});
            tick(2);
            chk(pad_oe_n, rows[m][31:24]);
            chk(pad_pull_up, rows[m][23:16]);
            chk(pad_pull_down, rows[m][15:8]);
            chk(pad_in_en, rows[m][7:0]);
            chk(pad_out & ~rows[m][31:24], 8'h0f & ~rows[m][31:24]);
        end
        $display("end of test drive modes");
        apb(1, `GPP_OFS_DRIVE_MODE, {8{`GPP_DM_STRONG}});
        // input and output enables both set on pins 0 to 3 only
        apb(1, `GPP_OFS_CONFIG, 32'h5a3c0f0f);
        tick(2);
        chk(pad_oe_n, 8'hf0);
        chk(pad_in_en, 8'h0f);
        chk(pad_vtrip_ttl, 8'h3c);
        chk(pad_slew_slow, 8'h5a);
        apb(1, `GPP_OFS_CONFIG, 32'h0000ffff);
        apb(1, `GPP_OFS_SOURCE_SEL, 32'h5555);
        tick(2);
        chk(pad_out, 8'h3c);
        apb(1, `GPP_OFS_SOURCE_SEL, 32'haaaa);
        tick(6);
        chk(pad_out, 8'hc3);
        chk(fabric_in, 8'hc3);
        $display("end of test config and sources");
        apb(1, `GPP_OFS_SOURCE_SEL, 32'h0);
        apb(1, `GPP_OFS_DRIVE_MODE, {8{`GPP_DM_INPUT}});
        @(posedge pclk);
        ext_en <= 8'hff;
        ext_drive <= 8'ha5;
        tick(4);
        apb(0, `GPP_OFS_PIN_STATE, 0);
        chk(rv, 32'ha5);
        @(posedge pclk);
        ext_drive <= 8'h00;
        tick(5);
        apb(1, `GPP_OFS_IRQ_CLEAR, 32'hff);
        apb(1, `GPP_OFS_IRQ_STATUS, 32'hff);
        apb(0, `GPP_OFS_IRQ_STATUS, 0);
        chk(rv, 32'h0);
        @(posedge pclk);
        ext_drive <= 8'h01;
        tick(5);
        apb(0, `GPP_OFS_IRQ_STATUS, 0);
        chk(rv, 32'h01);
        chk(port_irq, 1'b0);
        apb(1, `GPP_OFS_IRQ_ENABLE, 32'h01);
        tick(2);
        chk(port_irq, 1'b1);
        apb(1, `GPP_OFS_IRQ_CLEAR, 32'h01);
        tick(2);
        chk(port_irq, 1'b0);
        // falling edge selected on pin 0
        apb(1, `GPP_OFS_IRQ_EDGE, 32'h01);
        @(posedge pclk);
        ext_drive <= 8'h00;
        tick(5);
        apb(0, `GPP_OFS_IRQ_STATUS, 0);
        chk(rv, 32'h01);
        chk(port_irq, 1'b1);
        apb(1, `GPP_OFS_IRQ_CLEAR, 32'h01);
        tick(2);
        chk(port_irq, 1'b0);
        $display("end of test pin state and interrupt");
        apb(1, `GPP_OFS_DRIVE_MODE, {8{`GPP_DM_STRONG}});
        apb(1, `GPP_OFS_DATA_OUT, 32'h0f);
        tick(2);
        apb(1, `GPP_OFS_HOLD, 32'h1);
        apb(1, `GPP_OFS_DATA_OUT, 32'hf0);
        tick(3);
        chk(pad_out, 8'h0f);
        @(posedge pclk);
        low_power <= 1;
        apb(1, `GPP_OFS_HOLD, 32'h0);
        tick(3);
        chk(pad_out, 8'h0f);
        @(posedge pclk);
        low_power <= 0;
        tick(3);
        chk(pad_out, 8'hf0);
        apb(0, 12'hff0, 0);
        chk(ev, 1'b1);
        chk(rv, 32'h0);
        $display("end of test hold and refusal");
        // second reset while the pads are driving
        @(posedge pclk);
        presetn <= 0;
        tick(2);
        chk(pad_oe_n, 8'hff);
        chk(pad_out, 8'h00);
        chk(pad_in_en, 8'h00);
        @(posedge pclk);
        presetn <= 1;
        tick(1);
        apb(0, `GPP_OFS_DRIVE_MODE, 0);
        chk(rv, 32'h0);
        $display("end of test mid-run reset");
        final_report();
    end
endmodule
